// ==== verilog/reset_seq_pkg.sv ====
/*
 * Constants and types for the on-chip reset sequencer:
 * start-up delay, program counter widths, reset-cause flag values, states.
 * Assumes a single 100 MHz clock that stands for the private RC oscillator.
 */
package reset_seq_pkg;

    // clock rate of the private timing source
    localparam int unsigned CLK_FREQ_KHZ = 100000;
    // nominal start-up delay in milliseconds
    localparam int unsigned STARTUP_DELAY_MS = 18;
    // nominal delay, so neither rounded up nor down
    localparam int unsigned STARTUP_DELAY_CYCLES = STARTUP_DELAY_MS * CLK_FREQ_KHZ;

    // program counter widths per memory size
    localparam int unsigned PC_W_512 = 9;
    localparam int unsigned PC_W_1K = 10;
    localparam int unsigned PC_W_2K = 11;
    localparam int unsigned PC_W_MAX = PC_W_2K;

    // flag values after power-on
    localparam logic TIMEOUT_FLAG_POR = 1'b1;
    localparam logic POWERDOWN_FLAG_POR = 1'b1;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_COUNT = 3'b010,
        ST_RUN = 3'b100
    } seq_state_t;

endpackage

// ==== verilog/power_on_reset_start_timer.sv ====
/*
 * Power-on reset latch, start-up delay timer, reset-cause flags and the
 * program counter reset/wrap behaviour of a small microcontroller core.
 * Assumes all inputs are synchronous to ref_clk_in; reset_in marks power
 * appearing; the core drives the pc stepping and sleep/instruction strobes.
 */
`timescale 1ns/1ps
`default_nettype none

module power_on_reset_start_timer
    import reset_seq_pkg::*;
#(
    parameter int unsigned PC_W = reset_seq_pkg::PC_W_512,
    parameter int unsigned DELAY_LIMIT = reset_seq_pkg::STARTUP_DELAY_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic external_clear_n_in,
    input wire logic watchdog_timeout_source_in,
    input wire logic core_sleep_in,
    input wire logic sleep_exec_in,
    input wire logic clrwdt_exec_in,
    input wire logic pc_advance_in,
    input wire logic pc_load_in,
    input wire logic [reset_seq_pkg::PC_W_MAX-1:0] pc_load_addr_in,
    output logic core_reset_out,
    output logic timeout_flag_out,
    output logic powerdown_flag_out,
    output logic [PC_W-1:0] pc_out
);
    import reset_seq_pkg::*;

    localparam int unsigned CNT_W = $clog2(DELAY_LIMIT + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DELAY_LIMIT - 1);

    // one decode shared by the sequencer, the flags and the pc
    function automatic logic is_running(input seq_state_t st);
        return st == ST_RUN;
    endfunction
    // reset vector: top of the implemented program space
    localparam logic [PC_W-1:0] RESET_VECTOR = {PC_W{1'b1}};

    ////////////////////////////////////////////////////////////////////////
    // sequencer state and delay timer

    seq_state_t state;
    seq_state_t next_state;
    logic [CNT_W-1:0] delay_count;
    logic [CNT_W-1:0] next_delay_count;
    logic reset_latch;
    logic next_reset_latch;

    // ref_clk_in stands in for the private rc source, so the delay does not
    // depend on any main oscillator mode
    always_comb begin
        next_state = state;
        next_delay_count = delay_count;
        unique case (state)
            ST_HOLD: begin
                next_delay_count = '0;
                if (external_clear_n_in) begin
                    next_state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (!external_clear_n_in) begin
                    next_state = ST_HOLD;
                    next_delay_count = '0;
                end else if (watchdog_timeout_source_in) begin
                    next_delay_count = '0;
                end else if (delay_count == CNT_LAST) begin
                    next_state = ST_RUN;
                    next_delay_count = '0;
                end else begin
                    next_delay_count = delay_count + 1'b1;
                end
            end
            ST_RUN: begin
                if (!external_clear_n_in) begin
                    next_state = ST_HOLD;
                end else if (watchdog_timeout_source_in) begin
                    next_state = ST_COUNT;
                end
                next_delay_count = '0;
            end
            default: begin
                next_state = ST_HOLD;
                next_delay_count = '0;
            end
        endcase
        // the latch mirrors the sequencer so the core never runs early
        next_reset_latch = !is_running(next_state);
    end

    // only reset_in (power appearing) forces the latch; there is no supply
    // monitor, so a dip must be handled through the clear pin
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state <= ST_HOLD;
            delay_count <= '0;
            reset_latch <= 1'b1;
        end else begin
            state <= next_state;
            delay_count <= next_delay_count;
            reset_latch <= next_reset_latch;
        end
    end

    assign core_reset_out = reset_latch;

    ////////////////////////////////////////////////////////////////////////
    // reset-cause flags

    logic timeout_flag;
    logic powerdown_flag;
    logic next_timeout_flag;
    logic next_powerdown_flag;

    // reset events outrank the instruction strobes in the same cycle
    always_comb begin
        next_timeout_flag = timeout_flag;
        next_powerdown_flag = powerdown_flag;
        if (is_running(state) && !external_clear_n_in) begin
            // awake: a clear-pin reset leaves both flags as they were
            if (core_sleep_in) begin
                next_timeout_flag = 1'b1;
                next_powerdown_flag = 1'b0;
            end
        end else if (state != ST_HOLD && watchdog_timeout_source_in) begin
            next_timeout_flag = 1'b0;
            next_powerdown_flag = !core_sleep_in;
        end else if (is_running(state) && clrwdt_exec_in) begin
            next_timeout_flag = 1'b1;
            next_powerdown_flag = 1'b1;
        end else if (is_running(state) && sleep_exec_in) begin
            next_timeout_flag = 1'b1;
            next_powerdown_flag = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            timeout_flag <= TIMEOUT_FLAG_POR;
            powerdown_flag <= POWERDOWN_FLAG_POR;
        end else begin
            timeout_flag <= next_timeout_flag;
            powerdown_flag <= next_powerdown_flag;
        end
    end

    assign timeout_flag_out = timeout_flag;
    assign powerdown_flag_out = powerdown_flag;

    ////////////////////////////////////////////////////////////////////////
    // program counter

    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] next_pc;

    always_comb begin
        next_pc = pc;
        if (!is_running(next_state)) begin
            // held at the vector, so every release starts there
            next_pc = RESET_VECTOR;
        end else if (is_running(state) && pc_load_in) begin
            // upper address bits beyond memory are dropped
            next_pc = pc_load_addr_in[PC_W-1:0];
        end else if (is_running(state) && pc_advance_in) begin
            // natural overflow takes the vector to 000h
            next_pc = pc + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            pc <= RESET_VECTOR;
        end else begin
            pc <= next_pc;
        end
    end

    assign pc_out = pc;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_timer_done;
        state == ST_COUNT && delay_count == CNT_LAST && external_clear_n_in
            && !watchdog_timeout_source_in;
    endsequence

    sequence s_released;
        !core_reset_out && pc_out == RESET_VECTOR;
    endsequence

    sequence s_watchdog_in_run;
        state == ST_RUN && external_clear_n_in && watchdog_timeout_source_in;
    endsequence

    sequence s_watchdog_in_count;
        state == ST_COUNT && external_clear_n_in && watchdog_timeout_source_in;
    endsequence

    // an ordinary counting step: pin high, no time-out, end not reached
    sequence s_count_step;
        state == ST_COUNT && external_clear_n_in && !watchdog_timeout_source_in
            && delay_count != CNT_LAST;
    endsequence

    AST_POR_HOLD: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        $fell(reset_in) |-> core_reset_out && delay_count == '0 && timeout_flag_out && powerdown_flag_out)
        else $error("power-up did not hold reset with flags set");

    AST_COUNT_NEEDS_HIGH: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        !external_clear_n_in |=> delay_count == '0 && core_reset_out)
        else $error("delay timer counted while clear pin low");

    AST_HOLD_KEEPS_FLAGS: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state == ST_HOLD && !external_clear_n_in |=> state == ST_HOLD && $stable(timeout_flag_out)
            && $stable(powerdown_flag_out))
        else $error("hold with the clear pin low left hold or moved the flags");

    AST_COUNT_STEP: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        s_count_step |=> state == ST_COUNT && delay_count == CNT_W'($past(delay_count) + 1'b1))
        else $error("delay timer did not step by one");

    // the pin or a time-out one cycle later may legally cut the run short
    AST_RELEASE: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        s_timer_done |=> s_released ##1 (state == ST_RUN || !$past(external_clear_n_in)
            || $past(watchdog_timeout_source_in)))
        else $error("timer end did not release reset at the vector");

    AST_HELD_WHILE_ACTIVE: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (state != ST_RUN) |-> core_reset_out && pc_out == RESET_VECTOR)
        else $error("core left reset while the delay timer was active");

    AST_WATCHDOG_RESTART: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        s_watchdog_in_run |=> core_reset_out && delay_count == '0 && !timeout_flag_out
            ##1 (delay_count == CNT_W'(1) || !$past(external_clear_n_in) || $past(watchdog_timeout_source_in)))
        else $error("watchdog time-out did not restart the delay");

    AST_WATCHDOG_IN_COUNT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        s_watchdog_in_count |=> state == ST_COUNT && delay_count == '0 && core_reset_out)
        else $error("watchdog time-out during the delay did not restart it");

    AST_WATCHDOG_FLAGS: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (state == ST_COUNT || state == ST_RUN) && external_clear_n_in && watchdog_timeout_source_in
            |=> !timeout_flag_out && powerdown_flag_out == !$past(core_sleep_in))
        else $error("watchdog time-out flags wrong");

    AST_CLRWDT_FLAGS: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state == ST_RUN && external_clear_n_in && !watchdog_timeout_source_in && clrwdt_exec_in
            |=> timeout_flag_out && powerdown_flag_out)
        else $error("clear-watchdog instruction did not set both flags");

    AST_SLEEP_FLAGS: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state == ST_RUN && external_clear_n_in && !watchdog_timeout_source_in && !clrwdt_exec_in
            && sleep_exec_in |=> timeout_flag_out && !powerdown_flag_out)
        else $error("sleep instruction flags wrong");

    AST_PC_STEP: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state == ST_RUN && next_state == ST_RUN && !pc_load_in && pc_advance_in
            |=> pc_out == PC_W'($past(pc_out) + 1'b1))
        else $error("pc did not step by one");

    AST_PC_WRAP: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state == ST_RUN && next_state == ST_RUN && !pc_load_in && pc_advance_in
            && pc_out == RESET_VECTOR |=> pc_out == '0)
        else $error("pc did not wrap from the vector to zero");

    AST_LOAD_WRAP: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state == ST_RUN && next_state == ST_RUN && pc_load_in
            |=> pc_out == $past(pc_load_addr_in[PC_W-1:0]))
        else $error("out-of-range load did not wrap into memory");

    AST_CLEAR_WAKE_FLAGS: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state == ST_RUN && !external_clear_n_in && core_sleep_in
            |=> timeout_flag_out && !powerdown_flag_out && core_reset_out)
        else $error("clear-pin wake flags wrong");

    AST_CLEAR_RUN_FLAGS: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state == ST_RUN && !external_clear_n_in && !core_sleep_in |=> $stable(timeout_flag_out)
            && $stable(powerdown_flag_out))
        else $error("clear-pin reset in run changed the flags");

    AST_ABORT_COUNT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        state == ST_COUNT && !external_clear_n_in |=> state == ST_HOLD && delay_count == '0
            && core_reset_out)
        else $error("clear pin low during counting did not restart");

endmodule
`default_nettype wire

// ==== tb/clear_supervisor.sv ====
/*
 * Behavioural model of the supervisor that drives the active-low clear pin.
 * Assumes the bench raises release_in once power is meant to be good.
 */
`timescale 1ns/1ps
`default_nettype none

module clear_supervisor (
    input wire logic ref_clk_in,
    input wire logic release_in,
    input wire logic [7:0] hold_cycles_in,
    output var logic external_clear_n_out
);
    logic [7:0] wait_cnt = 8'h00;

    initial external_clear_n_out = 1'b0;

    // pin held low until the supply has settled, then driven high
    always @(posedge ref_clk_in) begin
        if (!release_in) begin
            wait_cnt <= 8'h00;
            external_clear_n_out <= #1 1'b0; // may pull low again in mid-count
        end else if (wait_cnt < hold_cycles_in) begin
            wait_cnt <= wait_cnt + 8'h01;
        end else begin
            external_clear_n_out <= #1 1'b1;
        end
    end
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench: the sequencer in all three memory sizes against a model.
 * Assumes reset_seq_pkg and the clear_supervisor model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import reset_seq_pkg::*;
    localparam int DELAY = 8;
    logic ref_clk_in = 1'b0, reset_in = 1'b1, rel = 1'b0, wdt = 1'b0, sleep = 1'b0;
    logic s_exec = 1'b0, c_exec = 1'b0, adv = 1'b0, ld = 1'b0;
    logic [10:0] addr = 11'h000;
    logic clr_n, core_rst, to_f, dn_f, rst_1k, to_1k, dn_1k, rst_2k, to_2k, dn_2k;
    logic [8:0] pc9;
    logic [9:0] pc10;
    logic [10:0] pc11;
    int errors = 0, checks_done = 0, cycles = 0, seed = 32'h4ef5, p = 32'h7ff, m_to = 1, m_down = 1;
    int m_rst = 1;

    clear_supervisor u_clear_supervisor (.ref_clk_in(ref_clk_in), .release_in(rel),
        .hold_cycles_in(8'h03), .external_clear_n_out(clr_n));
    power_on_reset_start_timer #(.PC_W(PC_W_512), .DELAY_LIMIT(DELAY)) u_power_on_reset_start_timer (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .external_clear_n_in(clr_n),
        .watchdog_timeout_source_in(wdt), .core_sleep_in(sleep), .sleep_exec_in(s_exec),
        .clrwdt_exec_in(c_exec), .pc_advance_in(adv), .pc_load_in(ld), .pc_load_addr_in(addr),
        .core_reset_out(core_rst), .timeout_flag_out(to_f), .powerdown_flag_out(dn_f), .pc_out(pc9));
    power_on_reset_start_timer #(.PC_W(PC_W_1K), .DELAY_LIMIT(DELAY)) u_power_on_reset_start_timer_1k (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .external_clear_n_in(clr_n),
        .watchdog_timeout_source_in(wdt), .core_sleep_in(sleep), .sleep_exec_in(s_exec),
        .clrwdt_exec_in(c_exec), .pc_advance_in(adv), .pc_load_in(ld), .pc_load_addr_in(addr),
        .core_reset_out(rst_1k), .timeout_flag_out(to_1k), .powerdown_flag_out(dn_1k), .pc_out(pc10));
    power_on_reset_start_timer #(.PC_W(PC_W_2K), .DELAY_LIMIT(DELAY)) u_power_on_reset_start_timer_2k (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .external_clear_n_in(clr_n),
        .watchdog_timeout_source_in(wdt), .core_sleep_in(sleep), .sleep_exec_in(s_exec),
        .clrwdt_exec_in(c_exec), .pc_advance_in(adv), .pc_load_in(ld), .pc_load_addr_in(addr),
        .core_reset_out(rst_2k), .timeout_flag_out(to_2k), .powerdown_flag_out(dn_2k), .pc_out(pc11));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // inputs change 2 ns after the edge, after the supervisor pin has settled
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #2;
    endtask

    task automatic check_model();
        check(16'(core_rst), 16'(m_rst));
        check(16'(to_f), 16'(m_to));
        check(16'(dn_f), 16'(m_down));
        check(16'({rst_1k, to_1k, dn_1k}), 16'({m_rst[0], m_to[0], m_down[0]}));
        check(16'({rst_2k, to_2k, dn_2k}), 16'({m_rst[0], m_to[0], m_down[0]}));
        check(16'(pc9), 16'(p & 32'h1ff));
        check(16'(pc10), 16'(p & 32'h3ff));
        check(16'(pc11), 16'(p & 32'h7ff));
    endtask

    task automatic strobe(input int k);
        case (k)
            0: wdt = 1'b1;
            1: c_exec = 1'b1;
            2: s_exec = 1'b1;
            default: adv = 1'b1;
        endcase
        tick(1);
        {wdt, c_exec, s_exec, adv} = 4'h0;
        tick(1);
    endtask

    // n counts edges already spent since the edge that started the delay
    task automatic wait_run(input int n);
        while (core_rst === 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        check(16'(n), 16'(DELAY + 1));
        p = 32'h7ff;
        m_rst = 0;
        check_model();
    endtask

    task automatic pin_low_then_run();
        rel = 1'b0;
        tick(4);
        rel = 1'b1;
        while (clr_n !== 1'b1) tick(1);
        wait_run(0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial forever #5 ref_clk_in = ~ref_clk_in;

    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        tick(16);
        reset_in = 1'b0;
        check(16'(core_rst), 16'h0001);
        check_model();
        adv = 1'b1;
        tick(40);
        adv = 1'b0;
        check(16'(core_rst), 16'h0001);
        check_model();
        rel = 1'b1;
        while (clr_n !== 1'b1) tick(1);
        tick(4);
        rel = 1'b0;
        tick(DELAY);
        check(16'(core_rst), 16'h0001);
        rel = 1'b1;
        while (clr_n !== 1'b1) tick(1);
        wait_run(0);
        $display("test startup done");
        strobe(3);
        p = 0;
        check_model();
        for (int i = 0; i < 12; i++) begin
            addr = 11'($random(seed));
            ld = 1'b1;
            adv = i[0];
            tick(1);
            p = addr;
            check_model();
        end
        ld = 1'b0;
        adv = 1'b1;
        tick(1);
        adv = 1'b0;
        p++;
        check_model();
        $display("test pc done");
        strobe(0);
        check(16'(core_rst), 16'h0001);
        m_to = 0;
        wait_run(2);
        pin_low_then_run();
        sleep = 1'b1;
        strobe(0);
        m_down = 0;
        wait_run(2);
        m_to = 1;
        pin_low_then_run();
        sleep = 1'b0;
        strobe(1);
        m_down = 1;
        check_model();
        strobe(2);
        m_down = 0;
        check_model();
        // second time-out lands two edges into the delay and must restart it
        strobe(0);
        strobe(0);
        m_to = 0;
        m_down = 1;
        wait_run(2);
        $display("test flags done");
        finish_test();
    end
endmodule

`default_nettype wire
